// ==== rtl/watchdog_reset_source_logic.sv ====
// Watchdog counter, reset source flags and reset pin handling with APB access
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "wdt_params.svh"

module watchdog_reset_source_logic
   import wdt_pkg::*;
#(
   parameter int CLK_PS = `CLK_PS
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reset_input_pin_i,
   output logic reset_input_pin_o,
   output logic reset_input_pin_oe,
   input wire logic reset_mode_pin,
   output logic reset_output_pin_n,
   output logic internal_reset,
   output logic irq
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   // Spike rejection rounds down; acceptance must not exceed 500ns
   localparam int FILT_CYC = ((`SPIKE_NS * 1000) / CLK_PS) < 1 ? 1 :
                             ((`SPIKE_NS * 1000) / CLK_PS);
   // Short minimum: max(4 half periods, 500ns), rounded up in clocks
   localparam int MIN_PS = (`SHORT_TCL * CLK_PS / 2) > (`FILTER_NS * 1000) ?
                           (`SHORT_TCL * CLK_PS / 2) : (`FILTER_NS * 1000);
   localparam int LONG_PS = `LONG_TCL * CLK_PS / 2 + MIN_PS;
   // The measured count is one below the pulse length, so a floor gives a strict "longer than"
   localparam int LONG_CYC = LONG_PS / CLK_PS;
   localparam int SHORT_CYC = (MIN_PS + CLK_PS - FILT_CYC * CLK_PS - 1) / CLK_PS;

   // ----------------------------------------------------------------
   // Input synchroniser and spike filter
   // ----------------------------------------------------------------
   logic pin_s1_r, pin_s2_r, pin_f_r, pin_f_nxt;
   logic mode_s1_r, mode_s2_r;
   logic [7:0] filt_cnt_r, filt_cnt_nxt;
   always_comb begin
      pin_f_nxt = pin_f_r;
      filt_cnt_nxt = 8'h00;
      if (pin_s2_r != pin_f_r) begin
         filt_cnt_nxt = filt_cnt_r + 8'h01;
         if (filt_cnt_r >= 8'(FILT_CYC - 1)) begin
            pin_f_nxt = pin_s2_r;
            filt_cnt_nxt = 8'h00;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_f_r <= 1'b1;
         filt_cnt_r <= 8'h00;
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= reset_input_pin_i;
         pin_s2_r <= pin_s1_r;
         mode_s1_r <= reset_mode_pin;
         mode_s2_r <= mode_s1_r;
         pin_f_r <= pin_f_nxt;
         filt_cnt_r <= filt_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic prescale_select_bit_r, prescale_select_bit_nxt;
   logic disabled_r, disabled_nxt;
   logic bidir_reset_enable_r, bidir_reset_enable_nxt;
   logic [7:0] reload_value_field_r, reload_value_field_nxt;
   logic init_done_r, init_done_nxt;
   logic overflow_reset_flag_r, overflow_reset_flag_nxt;
   logic soft_reset_flag_r, soft_reset_flag_nxt;
   logic short_hw_reset_flag_r, short_hw_reset_flag_nxt;
   logic long_hw_reset_flag_r, long_hw_reset_flag_nxt;
   logic power_on_flag_r, power_on_flag_nxt;
   logic [1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
   logic [15:0] count_r, count_nxt;
   logic [6:0] pre_r, pre_nxt;
   logic [4:0] rst_cnt_r, rst_cnt_nxt;
   logic [31:0] prdata_nxt;
   logic irq_nxt;
   pin_state_t pst_r, pst_nxt;
   logic [10:0] low_cnt_r, low_cnt_nxt;

   logic wr, rd, service, end_of_init_instr, software_reset_instr, tick, overflow;
   logic hw_short, hw_long;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign service = wr && paddr == `OFF_CMD && pwdata[`CMD_SERVICE];
   assign end_of_init_instr = wr && paddr == `OFF_CMD && pwdata[`CMD_END_INIT];
   assign software_reset_instr = wr && paddr == `OFF_CMD && pwdata[`CMD_SOFT_RST];

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = a[1:0] == 2'b00 && a <= `OFF_COUNT;
   endfunction

   // ----------------------------------------------------------------
   // Prescaler and counter
   // ----------------------------------------------------------------
   // tick every 2 or 128 clocks
   assign tick = prescale_select_bit_r ? (pre_r == 7'(`DIV_SLOW - 1)) :
                                         (pre_r[0] == 1'b1);
   assign overflow = tick && !disabled_r && count_r == 16'hFFFF && rst_cnt_r == 5'h00;

   // ----------------------------------------------------------------
   // Hardware reset pulse measurement (mode pin high)
   // ----------------------------------------------------------------
   always_comb begin
      pst_nxt = pst_r;
      low_cnt_nxt = low_cnt_r;
      hw_short = 1'b0;
      hw_long = 1'b0;
      case (pst_r)
         ST_IDLE: begin
            low_cnt_nxt = 11'h000;
            // Our own drive lingers through the synchroniser; wait it out unmeasured
            if (!pin_f_r) begin
               pst_nxt = reset_input_pin_oe ? ST_WAIT_HIGH : ST_LOW;
            end
         end
         ST_LOW: begin
            if (low_cnt_r != 11'h7FF) begin
               low_cnt_nxt = low_cnt_r + 11'h001;
            end
            if (pin_f_r) begin
               pst_nxt = ST_IDLE;
               if (low_cnt_r >= 11'(LONG_CYC)) begin
                  hw_long = mode_s2_r;
               end else if (low_cnt_r >= 11'(SHORT_CYC)) begin
                  hw_short = mode_s2_r;
               end
            end
         end
         ST_WAIT_HIGH: begin
            if (pin_f_r) begin
               pst_nxt = ST_IDLE;
            end
         end
         default: pst_nxt = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Main next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      prescale_select_bit_nxt = prescale_select_bit_r;
      disabled_nxt = disabled_r;
      bidir_reset_enable_nxt = bidir_reset_enable_r;
      reload_value_field_nxt = reload_value_field_r;
      init_done_nxt = init_done_r;
      overflow_reset_flag_nxt = overflow_reset_flag_r;
      soft_reset_flag_nxt = soft_reset_flag_r;
      short_hw_reset_flag_nxt = short_hw_reset_flag_r;
      long_hw_reset_flag_nxt = long_hw_reset_flag_r;
      power_on_flag_nxt = power_on_flag_r;
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      count_nxt = count_r;
      pre_nxt = pre_r + 7'h01;
      rst_cnt_nxt = rst_cnt_r;
      prdata_nxt = 32'h0000_0000;

      if (prescale_select_bit_r ? pre_r == 7'(`DIV_SLOW - 1) : 1'b0) begin
         pre_nxt = 7'h00;
      end
      if (tick && !disabled_r) begin
         count_nxt = count_r + 16'h0001;
      end
      if (rst_cnt_r != 5'h00) begin
         rst_cnt_nxt = rst_cnt_r - 5'h01;
      end

      if (wr) begin
         case (paddr)
            `OFF_CTRL: begin
               prescale_select_bit_nxt = pwdata[`CTRL_PRESCALE];
               if (!init_done_r) begin
                  disabled_nxt = pwdata[`CTRL_DISABLE];
               end
               bidir_reset_enable_nxt = pwdata[`CTRL_BIDIR];
            end
            `OFF_RELOAD: reload_value_field_nxt = pwdata[7:0];
            `OFF_IRQ_MASK: irq_mask_nxt = pwdata[1:0];
            default: begin
            end
         endcase
      end
      if (service) begin
         count_nxt = {reload_value_field_nxt, 8'h00};
      end
      if (end_of_init_instr) begin
         init_done_nxt = 1'b1;
         overflow_reset_flag_nxt = 1'b0;
         soft_reset_flag_nxt = 1'b0;
         short_hw_reset_flag_nxt = 1'b0;
         long_hw_reset_flag_nxt = 1'b0;
         power_on_flag_nxt = 1'b0;
      end

      // Read data is registered in the setup phase so it stands through the access phase
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `OFF_CTRL: prdata_nxt = {29'h0, bidir_reset_enable_r, disabled_r,
                                     prescale_select_bit_r};
            `OFF_RELOAD: prdata_nxt = {24'h0, reload_value_field_r};
            `OFF_STATUS: prdata_nxt = {25'h0, !disabled_r, init_done_r, power_on_flag_r,
                                       long_hw_reset_flag_r, short_hw_reset_flag_r,
                                       soft_reset_flag_r, overflow_reset_flag_r};
            `OFF_IRQ_STAT: prdata_nxt = {30'h0, irq_stat_r};
            `OFF_IRQ_MASK: prdata_nxt = {30'h0, irq_mask_r};
            `OFF_COUNT: prdata_nxt = {16'h0, count_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      if (rd && paddr == `OFF_IRQ_STAT) begin
         // Clear only what was reported, so an event during setup is not lost
         irq_stat_nxt = irq_stat_r & ~prdata[1:0];
      end

      // Reset events: set wins over clears above.
      if (overflow || software_reset_instr || hw_short || hw_long) begin
         disabled_nxt = 1'b0;
         init_done_nxt = 1'b0;
         bidir_reset_enable_nxt = 1'b0;
         prescale_select_bit_nxt = 1'b0;
         reload_value_field_nxt = 8'h00;
         count_nxt = 16'h0000;
         pre_nxt = 7'h00;
         rst_cnt_nxt = 5'(`RESET_PULSE);
      end
      if (overflow) begin
         overflow_reset_flag_nxt = 1'b1;
         irq_stat_nxt[`IRQ_OVERFLOW] = 1'b1;
      end
      if (software_reset_instr) begin
         soft_reset_flag_nxt = 1'b1;
      end
      if (hw_short || hw_long) begin
         short_hw_reset_flag_nxt = 1'b1;
         irq_stat_nxt[`IRQ_HW_RESET] = 1'b1;
      end
      if (hw_long) begin
         long_hw_reset_flag_nxt = 1'b1;
      end
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_select_bit_r <= 1'b0;
         disabled_r <= 1'b0;
         bidir_reset_enable_r <= 1'b0;
         reload_value_field_r <= 8'h00;
         init_done_r <= 1'b0;
         overflow_reset_flag_r <= 1'b0;
         soft_reset_flag_r <= 1'b0;
         short_hw_reset_flag_r <= 1'b0;
         long_hw_reset_flag_r <= 1'b0;
         power_on_flag_r <= 1'b1;
         irq_stat_r <= 2'b00;
         irq_mask_r <= 2'b00;
         count_r <= 16'h0000;
         pre_r <= 7'h00;
         rst_cnt_r <= 5'h00;
         prdata <= 32'h0000_0000;
         irq <= 1'b0;
         pst_r <= ST_IDLE;
         low_cnt_r <= 11'h000;
         internal_reset <= 1'b0;
         reset_output_pin_n <= 1'b0;
         reset_input_pin_oe <= 1'b0;
      end else begin
         prescale_select_bit_r <= prescale_select_bit_nxt;
         disabled_r <= disabled_nxt;
         bidir_reset_enable_r <= bidir_reset_enable_nxt;
         reload_value_field_r <= reload_value_field_nxt;
         init_done_r <= init_done_nxt;
         overflow_reset_flag_r <= overflow_reset_flag_nxt;
         soft_reset_flag_r <= soft_reset_flag_nxt;
         short_hw_reset_flag_r <= short_hw_reset_flag_nxt;
         long_hw_reset_flag_r <= long_hw_reset_flag_nxt;
         power_on_flag_r <= power_on_flag_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         count_r <= count_nxt;
         pre_r <= pre_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         prdata <= prdata_nxt;
         irq <= irq_nxt;
         pst_r <= pst_nxt;
         low_cnt_r <= low_cnt_nxt;
         internal_reset <= rst_cnt_nxt != 5'h00;
         // Output stays low during power-on reset until first clock
         reset_output_pin_n <= rst_cnt_nxt == 5'h00 && pin_f_r;
         // Bidir drive uses the enable sampled before the sequence clears it
         reset_input_pin_oe <= (overflow || software_reset_instr) ?
                               (bidir_reset_enable_r && mode_s2_r) :
                               (reset_input_pin_oe && rst_cnt_nxt != 5'h00);
      end
   end

   assign reset_input_pin_o = 1'b0;
   // Registered answer: no wait states, slverr on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         pslverr <= psel && !penable && !addr_ok(paddr);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      if (presetn) begin
         service_load_a: assert (!($past(service) && $past(presetn) && !$past(overflow)
            && !$past(software_reset_instr) && !$past(hw_short) && !$past(hw_long))
            || count_r[7:0] == 8'h00) else $error("service did not clear low byte");
      end
   end
   overflow_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      overflow |=> internal_reset && !reset_output_pin_n && overflow_reset_flag_r)
      else $error("overflow gave no reset");
   end_init_a: assert property (@(posedge pclk) disable iff (!presetn)
      end_of_init_instr && !overflow && !software_reset_instr && !hw_short && !hw_long |=>
      !power_on_flag_r && !soft_reset_flag_r && init_done_r)
      else $error("end of init left flags");
   disable_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      init_done_r && !disabled_r |=> !disabled_r)
      else $error("watchdog disabled after init");
   reload_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      service && !overflow && !software_reset_instr && !hw_short && !hw_long
      |=> count_r[15:8] == $past(reload_value_field_nxt))
      else $error("reload not loaded");
   slow_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && prescale_select_bit_r |=> (!tick || !prescale_select_bit_r) [*8])
      else $error("slow prescale too fast");
   soft_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      software_reset_instr |=> soft_reset_flag_r ##1 internal_reset)
      else $error("soft reset not flagged");
   mode_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      software_reset_instr && !mode_s2_r |=> !reset_input_pin_oe)
      else $error("pin driven with mode pin low");
   bidir_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      overflow |=> !bidir_reset_enable_r)
      else $error("bidir enable not cleared");
endmodule

// ==== rtl/wdt_params.svh ====
// Constants for the watchdog and reset-source block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// Register byte addresses
`define OFF_CTRL     12'h000
`define OFF_RELOAD   12'h004
`define OFF_CMD      12'h008
`define OFF_STATUS   12'h00C
`define OFF_IRQ_STAT 12'h010
`define OFF_IRQ_MASK 12'h014
`define OFF_COUNT    12'h018
// Control register fields
`define CTRL_PRESCALE 0
`define CTRL_DISABLE  1
`define CTRL_BIDIR    2
// Command register fields (write one to act)
`define CMD_SERVICE   0
`define CMD_END_INIT  1
`define CMD_SOFT_RST  2
// Status register fields (reset source flags and state)
`define ST_OVERFLOW   0
`define ST_SOFT       1
`define ST_SHORT_HW   2
`define ST_LONG_HW    3
`define ST_POWER_ON   4
`define ST_INIT_DONE  5
`define ST_RUNNING    6
// Interrupt status fields
`define IRQ_OVERFLOW  0
`define IRQ_HW_RESET  1
// Prescale ratios
`define DIV_SLOW 128
`define DIV_FAST 2
// Clock period in ps and timing
`define CLK_PS        40000
`define SPIKE_NS      50
`define FILTER_NS     500
// Half CPU clock periods: long reset threshold (1032 + 12) plus filter minimum
`define LONG_TCL      (1032 + 12)
`define SHORT_TCL     4
// Internal reset pulse length in clocks
`define RESET_PULSE   16
`endif

// ==== rtl/wdt_pkg.sv ====
// Types for the watchdog and reset-source block
package wdt_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_WAIT_HIGH = 3'b100
   } pin_state_t;
endpackage

// ==== verif/reset_src_model.sv ====
// Model of the external reset circuitry that shares the reset input pin
`timescale 1ns/1ps

module reset_src_model (
   input wire logic pclk,
   input wire logic reset_input_pin_o,
   input wire logic reset_input_pin_oe,
   output logic pin_level
);
   logic pull_low_r = 1'b0;

   // ----------------------------------------
   // Wired level of the pin
   // ----------------------------------------
   // The pin has a pull-up: it reads high whenever no party pulls it down
   assign pin_level = ((reset_input_pin_oe && !reset_input_pin_o) || pull_low_r) ? 1'b0 : 1'b1;

   // ----------------------------------------
   // Reset request
   // ----------------------------------------
   // A one-cycle hold is a deliberate spike, shorter than any valid request
   task automatic hold_low(input int cycles);
      @(posedge pclk);
      pull_low_r <= 1'b1;
      repeat (cycles) @(posedge pclk);
      pull_low_r <= 1'b0;
   endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking testbench for the watchdog and reset-source block
`timescale 1ns/1ps
`include "wdt_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin_level;
   logic pin_o;
   logic pin_oe;
   logic reset_mode_pin = 1'b1;
   logic reset_output_pin_n;
   logic internal_reset;
   logic irq;
   logic [31:0] rdata;
   logic err;
   logic oe_seen;
   logic out_seen_low;
   int plen;
   int wait_n;
   int fail_count = 0;
   int comparisons = 0;

   always #20 pclk = ~pclk;

   watchdog_reset_source_logic DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reset_input_pin_i(pin_level),
      .reset_input_pin_o(pin_o), .reset_input_pin_oe(pin_oe), .reset_mode_pin(reset_mode_pin),
      .reset_output_pin_n(reset_output_pin_n), .internal_reset(internal_reset), .irq(irq));

   reset_src_model src (.pclk(pclk), .reset_input_pin_o(pin_o), .reset_input_pin_oe(pin_oe),
      .pin_level(pin_level));

   // ----------------------------------------
   // Bus and wait helpers
   // ----------------------------------------
   // Response and read data are taken at the edge that finds pready high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      err = pslverr;
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wait_pulse();
      int n;
      n = 0;
      plen = 0;
      oe_seen = 1'b0;
      out_seen_low = 1'b0;
      #1;
      while (internal_reset !== 1'b1 && n < 40000) begin
         @(posedge pclk);
         #1;
         n++;
      end
      wait_n = n;
      while (internal_reset === 1'b1 && plen < 100) begin
         oe_seen |= (pin_oe === 1'b1);
         out_seen_low |= (reset_output_pin_n === 1'b0);
         @(posedge pclk);
         #1;
         plen++;
      end
      repeat (3) @(posedge pclk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(`OFF_STATUS);
      `CHK(rdata[6:0], 7'h50)
      rd(`OFF_CTRL);
      `CHK(rdata[2:0], 3'h0)
      rd(12'h100);
      `CHK(err, 1'b1)
      wr(`OFF_IRQ_MASK, 32'h0000_0001);
   endtask

   task automatic t_disable();
      wr(`OFF_CTRL, 32'h0000_0002);
      rd(`OFF_STATUS);
      `CHK(rdata[`ST_RUNNING], 1'b0)
      wr(`OFF_CTRL, 32'h0000_0000);
      wr(`OFF_CMD, 32'h0000_0002);
      rd(`OFF_STATUS);
      `CHK(rdata[6:0], 7'h60)
      wr(`OFF_CTRL, 32'h0000_0002);
      rd(`OFF_STATUS);
      `CHK(rdata[`ST_RUNNING], 1'b1)
   endtask

   // Bidir enable only reaches the pin when the mode pin is high
   task automatic t_soft(input logic mode);
      reset_mode_pin <= mode;
      wr(`OFF_CTRL, 32'h0000_0004);
      wr(`OFF_CMD, 32'h0000_0004);
      wait_pulse();
      `CHK(oe_seen, mode)
      `CHK(pin_o, 1'b0)
      `CHK(plen, `RESET_PULSE)
      rd(`OFF_STATUS);
      `CHK(rdata[`ST_SOFT], 1'b1)
      `CHK(rdata[`ST_INIT_DONE], 1'b0)
      rd(`OFF_CTRL);
      `CHK(rdata[2:0], 3'h0)
   endtask

   task automatic t_overflow(input logic sel);
      int div;
      div = sel ? `DIV_SLOW : `DIV_FAST;
      wr(`OFF_RELOAD, 32'h0000_00FF);
      wr(`OFF_CTRL, {31'h0000_0000, sel});
      wr(`OFF_CMD, 32'h0000_0001);
      rd(`OFF_COUNT);
      `CHK(rdata[15:8], 8'hFF)
      `CHK(rdata[7:0] < 8'h08, 1'b1)
      wait_pulse();
      `CHK(wait_n > 256 * div - div - 12 && wait_n < 256 * div + div, 1'b1)
      `CHK(out_seen_low, 1'b1)
      `CHK(plen, `RESET_PULSE)
      `CHK(irq, 1'b1)
      rd(`OFF_STATUS);
      `CHK(rdata[`ST_OVERFLOW], 1'b1)
      rd(`OFF_IRQ_STAT);
      `CHK(rdata[`IRQ_OVERFLOW], 1'b1)
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
   endtask

   // Flags accumulate across resets, so each step checks its own bits
   task automatic t_hw();
      reset_mode_pin <= 1'b1;
      src.hold_low(1);
      repeat (60) @(posedge pclk);
      rd(`OFF_STATUS);
      `CHK(rdata[`ST_SHORT_HW], 1'b0)
      src.hold_low(20);
      repeat (60) @(posedge pclk);
      `CHK(irq, 1'b0)
      rd(`OFF_STATUS);
      `CHK(rdata[3:2], 2'h1)
      rd(`OFF_IRQ_STAT);
      `CHK(rdata[`IRQ_HW_RESET], 1'b1)
      src.hold_low(1200);
      repeat (60) @(posedge pclk);
      rd(`OFF_STATUS);
      `CHK(rdata[`ST_LONG_HW], 1'b1)
   endtask

   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task automatic end_sim();
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_disable();
      t_soft(1'b0);
      t_soft(1'b1);
      t_overflow(1'b0);
      t_overflow(1'b1);
      t_hw();
      end_sim();
   end

   // The slow overflow alone takes some 33000 cycles
   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      end_sim();
   end
endmodule
